/* File: tdsr_readout.sv */
// Purpose: steering flags and serial digit readout of a tone digit receiver
// Assumes: all pin inputs are asynchronous, analog front end is outside
// Notes: shift pulses are sampled by clk_i, so they must last over 10 ns

module tdsr_readout #(
	parameter int GUARD_ON_CYC = tdsr_pkg::TDSR_GUARD_ON_CYC,
	parameter int GUARD_OFF_CYC = tdsr_pkg::TDSR_GUARD_OFF_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// front end detector results
	input wire logic tone_present_i,
	input wire logic [1:0] tone_row_i,
	input wire logic [1:0] tone_col_i,
	input wire logic energy_present_i,
	// variant strap, high selects delayed steering
	input wire logic delayed_steering_i,
	// controller side pins
	input wire logic shift_pulse_i,
	input wire logic sleep_request_i,
	// outputs
	output logic early_tone_flag_o,
	output logic validated_digit_flag_o,
	output logic serial_out_cadence_o
);

	tdsr_pkg::tdsr_pins_t pins_in;
	tdsr_pkg::tdsr_pins_t meta_reg;
	tdsr_pkg::tdsr_pins_t pins_reg;
	tdsr_pkg::tdsr_state_t state_reg;
	tdsr_pkg::tdsr_state_t state_next;
	logic [3:0] digit_reg;
	logic [3:0] digit_next;
	logic [3:0] shreg_reg;
	logic [3:0] shreg_next;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic shift_prev_reg;
	logic steer_prev_reg;
	logic sd_reg;
	logic sd_next;
	logic early_reg;
	logic valid_flag_reg;
	logic guard_valid;

	// gather pins so one two-stage synchroniser covers them all
	assign pins_in.tone = tone_present_i;
	assign pins_in.energy = energy_present_i;
	assign pins_in.shift = shift_pulse_i;
	assign pins_in.sleep = sleep_request_i;
	assign pins_in.delayed = delayed_steering_i;
	assign pins_in.row = tone_row_i;
	assign pins_in.col = tone_col_i;

	// synchroniser, first stage feeds only the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= tdsr_pkg::TDSR_PINS_RST;
			pins_reg <= tdsr_pkg::TDSR_PINS_RST;
		end else begin
			meta_reg <= pins_in;
			pins_reg <= meta_reg;
		end
	end

	// sleep forces the sequencer, the guard and all three outputs idle
	wire logic asleep = pins_reg.sleep;

	// delayed steering validation
	tdsr_guard_timer #(
		.ON_CYC(GUARD_ON_CYC),
		.OFF_CYC(GUARD_OFF_CYC)
	) u_guard (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(asleep),
		.present_i(pins_reg.tone),
		.valid_o(guard_valid)
	);

	// code lookup by tone pair
	wire logic [3:0] lut_idx = {pins_reg.row, pins_reg.col};
	wire logic [3:0] lut_code =
		tdsr_pkg::TDSR_CODE_LUT[lut_idx * tdsr_pkg::TDSR_CODE_W
		+: tdsr_pkg::TDSR_CODE_W];

	// steering source picked by the variant strap
	wire logic steer = !asleep && (pins_reg.delayed ? guard_valid
		: pins_reg.tone);
	wire logic steer_rise = steer && !steer_prev_reg;
	wire logic shift_rise = pins_reg.shift && !shift_prev_reg;
	wire logic shift_fall = !pins_reg.shift && shift_prev_reg;

	// the digit follows the detector while a tone is present, so the
	// code is the last one heard even if the tone drops before readout
	assign digit_next = pins_reg.tone ? lut_code : digit_reg;

	// readout sequencer
	always_comb begin
		state_next = state_reg;
		shreg_next = shreg_reg;
		cnt_next = cnt_reg;
		unique case (state_reg)
			tdsr_pkg::TDSR_ST_WAIT: begin
				// extra pulses land here and do nothing
				if (steer_rise) begin
					state_next = tdsr_pkg::TDSR_ST_READY;
				end
			end
			tdsr_pkg::TDSR_ST_READY: begin
				if (shift_rise) begin
					shreg_next = digit_reg;
					cnt_next = tdsr_pkg::TDSR_CNT_FIRST;
					state_next = tdsr_pkg::TDSR_ST_SHIFT;
				end
			end
			tdsr_pkg::TDSR_ST_SHIFT: begin
				// steering rises are not seen here, a stalled transfer
				// must be finished before the next digit is captured
				if (shift_rise && cnt_reg != tdsr_pkg::TDSR_CNT_LAST) begin
					shreg_next = {1'b0, shreg_reg[3:1]};
					cnt_next = cnt_reg + 3'h1;
				end else if (shift_fall && cnt_reg == tdsr_pkg::TDSR_CNT_LAST) begin
					cnt_next = tdsr_pkg::TDSR_CNT_IDLE;
					state_next = tdsr_pkg::TDSR_ST_WAIT;
				end
			end
			default: begin
				state_next = tdsr_pkg::TDSR_ST_WAIT;
			end
		endcase
		if (asleep) begin
			state_next = tdsr_pkg::TDSR_ST_WAIT;
			cnt_next = tdsr_pkg::TDSR_CNT_IDLE;
		end
	end

	// shared pin: low in sleep, serial bit during a transfer, envelope otherwise
	wire logic serial_sel = state_next == tdsr_pkg::TDSR_ST_SHIFT;
	assign sd_next = asleep ? 1'b0
		: serial_sel ? shreg_next[0] : pins_reg.energy;

	// sequencer and output registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= tdsr_pkg::TDSR_ST_WAIT;
			shreg_reg <= tdsr_pkg::TDSR_CODE_RST;
			digit_reg <= tdsr_pkg::TDSR_CODE_RST;
			cnt_reg <= tdsr_pkg::TDSR_CNT_IDLE;
			shift_prev_reg <= 1'b0;
			steer_prev_reg <= 1'b0;
			sd_reg <= 1'b0;
			early_reg <= 1'b0;
			valid_flag_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			shreg_reg <= shreg_next;
			digit_reg <= digit_next;
			cnt_reg <= cnt_next;
			shift_prev_reg <= pins_reg.shift;
			steer_prev_reg <= steer;
			sd_reg <= sd_next;
			early_reg <= !asleep && pins_reg.tone;
			valid_flag_reg <= !asleep && guard_valid;
		end
	end

	assign early_tone_flag_o = early_reg;
	assign validated_digit_flag_o = valid_flag_reg;
	assign serial_out_cadence_o = sd_reg;

	sleep_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		asleep |=> !sd_reg && !early_reg && !valid_flag_reg)
		else $error("output not low while powered down");

	early_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!asleep |=> early_reg == $past(pins_reg.tone))
		else $error("early flag does not follow tone detection");

	lsb_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == tdsr_pkg::TDSR_ST_READY && shift_rise && !asleep)
		|=> sd_reg == $past(digit_reg[0]) && shreg_reg == $past(digit_reg))
		else $error("first pulse did not latch code with lsb out");

	bit_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == tdsr_pkg::TDSR_ST_SHIFT && shift_rise && !asleep
		&& cnt_reg != tdsr_pkg::TDSR_CNT_LAST)
		|=> sd_reg == $past(shreg_reg[1]) && cnt_reg == $past(cnt_reg) + 3'h1)
		else $error("next bit not shifted out in ascending order");

	extra_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == tdsr_pkg::TDSR_ST_WAIT && !steer_rise)
		|=> state_reg == tdsr_pkg::TDSR_ST_WAIT && $stable(shreg_reg))
		else $error("pulse acted without a new steering rise");

	no_relatch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == tdsr_pkg::TDSR_ST_SHIFT && !asleep && !shift_fall)
		|=> state_reg == tdsr_pkg::TDSR_ST_SHIFT)
		else $error("unfinished transfer was abandoned");

	four_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == tdsr_pkg::TDSR_ST_SHIFT && shift_fall && !asleep
		&& cnt_reg == tdsr_pkg::TDSR_CNT_LAST)
		|=> state_reg == tdsr_pkg::TDSR_ST_WAIT && sd_reg == $past(pins_reg.energy))
		else $error("transfer did not end after fourth pulse fall");

	cadence_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg != tdsr_pkg::TDSR_ST_SHIFT && !shift_rise && !asleep)
		|=> sd_reg == $past(pins_reg.energy))
		else $error("cadence not shown outside a transfer");

	decode_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(pins_reg.tone && pins_reg.row == 2'h3 && pins_reg.col == 2'h3)
		|=> digit_reg == 4'h0)
		else $error("tone pair decoded to the wrong code");

endmodule

/* File: tdsr_pkg.sv */
// Purpose: shared constants and types for the tone digit serial readout
// Assumes: 100 MHz system clock, pins sampled through two flip-flops
// Notes: guard times are figures in microseconds, cycles derived from them
package tdsr_pkg;

	// system clock rate
	localparam int TDSR_CLK_MHZ = 100;

	// guard times of the delayed steering path, in microseconds
	localparam int TDSR_GUARD_ON_US = 40000;
	localparam int TDSR_GUARD_OFF_US = 40000;
	localparam int TDSR_GUARD_ON_CYC = TDSR_GUARD_ON_US * TDSR_CLK_MHZ;
	localparam int TDSR_GUARD_OFF_CYC = TDSR_GUARD_OFF_US * TDSR_CLK_MHZ;

	// digit code width and shift pulse counts
	localparam int TDSR_CODE_W = 4;
	localparam logic [2:0] TDSR_CNT_IDLE = 3'h0;
	localparam logic [2:0] TDSR_CNT_FIRST = 3'h1;
	localparam logic [2:0] TDSR_CNT_LAST = 3'h4;
	localparam logic [3:0] TDSR_CODE_RST = 4'h0;

	// code per tone pair, entry index {row, column}, entry 0 lowest
	// rows 697/770/852/941 Hz, columns 1209/1336/1477/1633 Hz
	localparam logic [63:0] TDSR_CODE_LUT = 64'h0cab_f987_e654_d321;

	// pins after synchronisation
	typedef struct packed {
		logic tone;
		logic energy;
		logic shift;
		logic sleep;
		logic delayed;
		logic [1:0] row;
		logic [1:0] col;
	} tdsr_pins_t;

	localparam tdsr_pins_t TDSR_PINS_RST = '0;

	// readout sequencer states
	typedef enum logic [1:0] {
		TDSR_ST_WAIT = 2'b00,
		TDSR_ST_READY = 2'b01,
		TDSR_ST_SHIFT = 2'b10
	} tdsr_state_t;

endpackage

/* File: tdsr_guard_timer.sv */
// Purpose: guard timing that turns early tone detection into a valid digit
// Assumes: present_i is already synchronous to clk_i
// Notes: the same counter times tone present and tone absent guards
module tdsr_guard_timer #(
	parameter int ON_CYC = 4000000,
	parameter int OFF_CYC = 4000000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic clear_i,
	input wire logic present_i,
	// result
	output logic valid_o
);

	localparam logic [31:0] ON_LIM = 32'(ON_CYC - 1);
	localparam logic [31:0] OFF_LIM = 32'(OFF_CYC - 1);

	logic valid_reg;
	logic valid_next;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;

	// a mismatch between input and output runs the counter
	wire logic differ = present_i != valid_reg;
	wire logic [31:0] lim = valid_reg ? OFF_LIM : ON_LIM;
	wire logic expired = differ && (cnt_reg == lim);

	// any blip shorter than the guard restarts the wait from zero
	always_comb begin
		valid_next = valid_reg;
		cnt_next = '0;
		if (clear_i) begin
			valid_next = 1'b0;
		end else if (expired) begin
			valid_next = present_i;
		end else if (differ) begin
			cnt_next = cnt_reg + 32'h1;
		end
	end

	// state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			valid_reg <= 1'b0;
			cnt_reg <= '0;
		end else begin
			valid_reg <= valid_next;
			cnt_reg <= cnt_next;
		end
	end

	assign valid_o = valid_reg;

	guard_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!valid_reg && !clear_i && !(present_i && cnt_reg == ON_LIM))
		|=> !valid_reg)
		else $error("digit validated before the guard time ran out");

endmodule

/* File: tdsr_ctrl_model.sv */
// Purpose: controller model that clocks digit bits out with shift pulses
// Assumes: pulses 80 ns high, 80 ns low, changed on clk_i rising edges
// Notes: samples the shared pin late in each high phase, past the sync
module tdsr_ctrl_model (
	// clock and request
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [2:0] npulse_i,
	// shared pins
	input wire logic sd_i,
	output logic shift_o,
	// results
	output logic done_o,
	output logic [3:0] bits_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int k;
	// idle low, so neither stray pulses nor power-down upset the device
	initial begin
		shift_o = 1'b0;
		done_o = 1'b0;
		bits_o = 4'h0;
		forever begin
			@(posedge clk_i);
			if (start_i) begin
				done_o <= 1'b0;
				for (k = 0; k < npulse_i; k++) begin
					shift_o <= 1'b1;
					repeat (6) @(posedge clk_i);
					bits_o[k] <= sd_i;
					repeat (2) @(posedge clk_i);
					shift_o <= 1'b0;
					repeat (8) @(posedge clk_i);
				end
				done_o <= 1'b1;
			end
		end
	end
endmodule

/* File: tb.sv */
// Purpose: self-checking bench of the tone digit serial readout
// Assumes: short guard counts, controller model on the shift pin
// Notes: cadence input held high so digit bits stand out against it
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int GON = 20;
	// expected code per {row, col}, entry 0 lowest
	localparam logic [63:0] EXP_CODES = 64'h0cab_f987_e654_d321;
	logic clk_i = 1'b0, rst_i = 1'b1, tone = 1'b0, energy = 1'b0;
	logic strap = 1'b0, sleep = 1'b0, start = 1'b0;
	logic [1:0] row = 2'h0, col = 2'h0;
	logic [2:0] npulse = 3'h4;
	logic shift, done, f_early, f_valid, sd;
	logic [3:0] bits;
	int err_count = 0, total_checks = 0;

	tdsr_readout #(.GUARD_ON_CYC(GON), .GUARD_OFF_CYC(GON)) tdsr_readout_inst (
		.clk_i(clk_i), .rst_i(rst_i), .tone_present_i(tone),
		.tone_row_i(row), .tone_col_i(col), .energy_present_i(energy),
		.delayed_steering_i(strap), .shift_pulse_i(shift),
		.sleep_request_i(sleep), .early_tone_flag_o(f_early),
		.validated_digit_flag_o(f_valid), .serial_out_cadence_o(sd));
	tdsr_ctrl_model tdsr_ctrl_model_inst (
		.clk_i(clk_i), .start_i(start), .npulse_i(npulse), .sd_i(sd),
		.shift_o(shift), .done_o(done), .bits_o(bits));

	// free running external clock
	initial forever #5 clk_i = ~clk_i;

	task automatic give_verdict();
		$display("checks %0d, errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [3:0] seen,
		input logic [3:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one burst of n pulses, bounded wait for the model
	task automatic read(input logic [2:0] n);
		int i;
		npulse <= n;
		start <= 1'b1;
		step(1);
		start <= 1'b0;
		step(1);
		for (i = 0; i < 200 && done !== 1'b1; i++) step(1);
		if (done !== 1'b1) begin
			err_count++;
			give_verdict();
		end
	endtask
	task automatic wait_valid(input logic lvl);
		int i;
		for (i = 0; i < 40 && f_valid !== lvl; i++) step(1);
		check("valid flag", f_valid, lvl);
		if (f_valid !== lvl) give_verdict();
	endtask
	task automatic set_tone(input logic on, input logic [3:0] idx);
		row <= idx[3:2];
		col <= idx[1:0];
		tone <= on;
		step(8);
	endtask

	task automatic t_codes();
		logic [4:0] i;
		check("cadence low", sd, 1'b0);
		energy <= 1'b1;
		for (i = 0; i < 16; i++) begin
			set_tone(1'b1, i[3:0]);
			check("early flag", f_early, 1'b1);
			check("cadence high", sd, 1'b1);
			read(3'h4);
			check("digit code", bits, EXP_CODES[i*4+:4]);
			check("cadence after", sd, 1'b1);
			set_tone(1'b0, i[3:0]);
			check("early off", f_early, 1'b0);
		end
	endtask
	task automatic t_extra();
		set_tone(1'b1, 4'hf);
		read(3'h4);
		check("digit d", bits, 4'h0);
		read(3'h2);
		check("extra pulses", bits[1:0], 2'h3);
		set_tone(1'b0, 4'hf);
	endtask
	task automatic t_partial();
		set_tone(1'b1, 4'h8);
		read(3'h2);
		check("low half", bits[1:0], 2'h3);
		set_tone(1'b0, 4'h8);
		set_tone(1'b1, 4'h3);
		read(3'h2);
		check("old high half", bits[1:0], 2'h1);
		read(3'h4);
		check("no rearm", bits, 4'hf);
	endtask
	task automatic t_sleep();
		sleep <= 1'b1;
		step(5);
		check("sleep early", f_early, 1'b0);
		check("sleep cadence", sd, 1'b0);
		sleep <= 1'b0;
		step(5);
		check("wake early", f_early, 1'b1);
		// waking re-raises the flag, so the held tone arms a readout
		read(3'h4);
		check("wake digit", bits, 4'hd);
		set_tone(1'b0, 4'h3);
		// let the guard drop so the delayed test starts unarmed
		wait_valid(1'b0);
	endtask
	task automatic t_delay();
		strap <= 1'b1;
		set_tone(1'b1, 4'h5);
		check("valid early", f_valid, 1'b0);
		wait_valid(1'b1);
		read(3'h4);
		check("delayed code", bits, 4'h5);
		set_tone(1'b0, 4'h5);
		check("valid hold", f_valid, 1'b1);
		wait_valid(1'b0);
	endtask

	initial begin
		step(16);
		rst_i <= 1'b0;
		step(1);
		check("reset flags", {f_early, f_valid, sd}, 3'h0);
		step(4);
		t_codes();
		t_extra();
		t_partial();
		t_sleep();
		t_delay();
		give_verdict();
	end
endmodule
